// [iam_hart_master.sv]
`timescale 1ns/1ns
module iam_hart_master
(
  // Clock
  input  wire logic        core_clk_in,
  // Command out
  output logic             cmd_valid_out,
  output logic [7:0]       cmd_out,
  // Response in
  input  wire logic        resp_valid_in,
  input  wire logic        resp_ok_in,
  input  wire logic [31:0] status_in,
  input  wire logic [4:0]  cat_in
);
  initial cmd_valid_out = 1'b0;
  initial cmd_out = 8'h00;
  // One command, then wait for its one-cycle answer
  task automatic send(input logic [7:0] c, output logic ok, output logic [31:0] st,
                      output logic [4:0] ct);
    int n;
    begin
      n = 0;
      @(posedge core_clk_in);
      cmd_valid_out <= 1'b1;
      cmd_out <= c;
      @(posedge core_clk_in);
      cmd_valid_out <= 1'b0;
      // Idle bus shows garbage, not the last command
      cmd_out <= ~c;
      do
      begin
        @(posedge core_clk_in);
        n++;
      end
      while (resp_valid_in !== 1'b1 && n < 8);
      ok = resp_ok_in;
      st = status_in;
      ct = cat_in;
    end
  endtask : send
endmodule : iam_hart_master

// [iam_monitor.sv]
// The placing of the registers and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ns
module iam_monitor
  import iam_pkg::*;
#(
  parameter logic [31:0] DRV_HOLD = DRV_HOLD_CYC
)
(
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        arst_n_in,
  // Avalon-MM slave
  input  wire logic [5:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Failure reports from checkers
  input  wire logic        flash_fail_in,
  input  wire logic        ref_fail_in,
  input  wire logic        drive_cur_fail_in,
  input  wire logic        crit_mem_fail_in,
  input  wire logic        sensor_fail_in,
  // Activity
  input  wire logic        autocal_run_in,
  input  wire logic        cal_run_in,
  input  wire logic        diag_run_in,
  input  wire logic        diag_data_in,
  // Measurements
  input  wire logic [15:0] travel_in,
  input  wire logic [15:0] drive_in,
  input  wire logic [15:0] press_in,
  input  wire logic [15:0] press_sp_in,
  input  wire logic [11:0] loop_ma_in,
  input  wire logic        integ_hi_in,
  input  wire logic        integ_lo_in,
  // Field master command port
  input  wire logic        hart_cmd_valid_in,
  input  wire logic [7:0]  hart_cmd_in,
  output logic             hart_resp_valid_out,
  output logic             hart_resp_ok_out,
  output logic [31:0]      hart_status_out,
  output logic [N_CAT-1:0] hart_cat_out,
  // Status
  output logic [31:0]      alerts_out,
  output logic             rec_full_out,
  output logic             rec_not_empty_out,
  output logic             autocal_busy_out,
  output logic             cal_busy_out,
  output logic             diag_busy_out,
  output logic             control_hold_out
);

  iam_state_t          st;
  iam_state_t          next_st;
  logic [31:0]         raw;
  logic [31:0]         active;
  logic [31:0]         newal;
  logic [31:0]         pnd;
  logic [N_CAT-1:0]    cats;
  logic [15:0]         pdiff;
  logic [4:0]          pick;
  logic                found;
  logic                drv_cond;
  logic                drv_held;
  logic                wr_go;

  // ---------------------------------------------------------------
  // Byte lane merge
  // ---------------------------------------------------------------
  function automatic logic [31:0] iam_merge(input logic [31:0] old_v,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction : iam_merge

  // ---------------------------------------------------------------
  // Drive signal qualification
  // ---------------------------------------------------------------
  always_comb
  begin
    if (!st.zp_open)
    begin
      drv_cond = (drive_in < DRV_LO && travel_in > TRV_LO) ||
                 (drive_in > DRV_HI && travel_in < TRV_HI);
    end
    else
    begin
      drv_cond = (drive_in < DRV_LO && travel_in < TRV_HI) ||
                 (drive_in > DRV_HI && travel_in > TRV_LO);
    end
  end

  iam_persist u_drv_hold (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .cond_in     (drv_cond),
    .limit_in    (DRV_HOLD),
    .held_out    (drv_held)
  );

  // ---------------------------------------------------------------
  // Raw conditions and enabled view
  // ---------------------------------------------------------------
  assign pdiff = (press_in > press_sp_in) ? press_in - press_sp_in
                                          : press_sp_in - press_in;

  always_comb
  begin
    raw            = '0;
    raw[A_FLASH]   = st.flash_l;
    raw[A_REF]     = ref_fail_in;
    raw[A_DRVCUR]  = drive_cur_fail_in;
    raw[A_CRITMEM] = st.crit_l;
    raw[A_SENSOR]  = sensor_fail_in;
    raw[A_LOOP]    = st.loop_l;
    raw[A_RNE]     = st.cnt != 5'h00;
    raw[A_RFULL]   = st.cnt == REC_FULL;
    raw[A_CAL]     = st.cal_b;
    raw[A_AUTOCAL] = st.acal_b;
    raw[A_DIAG]    = st.diag_b;
    raw[A_CYC]     = st.cyc > st.cyc_pt;
    raw[A_TIME]    = st.time_apx;
    raw[A_DDATA]   = diag_data_in;
    raw[A_EPP]     = st.pmode && pdiff > st.allow;
    raw[A_INTHI]   = integ_hi_in;
    raw[A_INTLO]   = integ_lo_in;
    raw[A_DRVSIG]  = drv_held;
    raw[A_OFFL]    = st.offl;
  end

  assign active = raw & st.en;
  assign newal  = active & ~st.prev;
  assign pnd    = st.pend | newal;
  assign wr_go  = avs_write_in && st.ack;

  always_comb
  begin
    cats = '0;
    for (int i = 0; i < N_AL; i++)
    begin
      if (active[i])
      begin
        cats[int'(IAM_CAT[i])] = 1'b1;
      end
    end
  end

  always_comb
  begin
    pick  = '0;
    found = 1'b0;
    for (int i = 0; i < N_AL; i++)
    begin
      if (!found && pnd[i])
      begin
        found = 1'b1;
        pick  = 5'(i);
      end
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_st         = st;
    next_st.prev    = active;
    next_st.flash_l = st.flash_l | flash_fail_in;
    next_st.crit_l  = st.crit_l | crit_mem_fail_in;
    next_st.cal_b   = cal_run_in;
    next_st.acal_b  = autocal_run_in;
    next_st.diag_b  = diag_run_in;
    next_st.offl    = st.offl | (|(active & st.shdn));

    // Loop check: first cycle after restart, then gross limits
    next_st.loop_chk = 1'b1;
    if (!st.loop_chk && (loop_ma_in < LOOP_MIN || loop_ma_in > LOOP_MAX))
    begin
      next_st.loop_l = 1'b1;
    end
    if (loop_ma_in < GROSS_LO || loop_ma_in > GROSS_HI)
    begin
      next_st.loop_l = 1'b1;
    end

    // Reversal tracking; reference follows travel in current direction
    if (st.dir_up)
    begin
      if (travel_in > st.ref_pt)
      begin
        next_st.ref_pt = travel_in;
      end
      else if (st.ref_pt - travel_in > st.dband)
      begin
        next_st.cyc    = st.cyc + 32'h00000001;
        next_st.dir_up = 1'b0;
        next_st.ref_pt = travel_in;
      end
    end
    else
    begin
      if (travel_in < st.ref_pt)
      begin
        next_st.ref_pt = travel_in;
      end
      else if (travel_in - st.ref_pt > st.dband)
      begin
        next_st.cyc    = st.cyc + 32'h00000001;
        next_st.dir_up = 1'b1;
        next_st.ref_pt = travel_in;
      end
    end

    // One record entry per cycle; when full, pending ones are lost
    next_st.pend = pnd;
    if (found)
    begin
      if (st.cnt != REC_FULL)
      begin
        next_st.rec[st.cnt] = pick;
        next_st.cnt         = st.cnt + 5'h01;
        next_st.pend[pick]  = 1'b0;
      end
      else
      begin
        next_st.pend = '0;
      end
    end

    // Field master status read
    next_st.hresp = hart_cmd_valid_in;
    if (hart_cmd_valid_in)
    begin
      next_st.hok   = hart_cmd_in == HART_CMD_STATUS;
      next_st.hstat = (hart_cmd_in == HART_CMD_STATUS) ? active : '0;
      next_st.hcat  = (hart_cmd_in == HART_CMD_STATUS) ? cats : '0;
    end

    // Bus handshake: one wait cycle, then the access completes
    next_st.ack = (avs_read_in || avs_write_in) && !st.ack;
    if (avs_read_in && !st.ack)
    begin
      case (avs_address_in)
        R_STATUS: next_st.rdata = active;
        R_EN:     next_st.rdata = st.en;
        R_SHDN:   next_st.rdata = st.shdn;
        R_CFG:    next_st.rdata = {30'h0, st.pmode, st.zp_open};
        R_RINFO:  next_st.rdata = {22'h0, raw[A_RNE], raw[A_RFULL], 3'h0, st.cnt};
        R_RSEL:   next_st.rdata = {27'h0, st.sel};
        R_RDATA:  next_st.rdata = (st.sel < st.cnt) ? {27'h0, st.rec[st.sel]} : '0;
        R_CYC:    next_st.rdata = st.cyc;
        R_CYCPT:  next_st.rdata = st.cyc_pt;
        R_DBAND:  next_st.rdata = {16'h0, st.dband};
        R_ALLOW:  next_st.rdata = {16'h0, st.allow};
        R_TIME:   next_st.rdata = st.tm;
        R_CATS:   next_st.rdata = {27'h0, cats};
        default:  next_st.rdata = '0;
      endcase
    end

    if (wr_go)
    begin
      case (avs_address_in)
        R_EN:
        begin
          // Checker failure alerts (bits 0 to 4) cannot be switched off; loop and offline alerts can
          next_st.en = iam_merge(st.en, avs_writedata_in, avs_byteenable_in)
                       | EN_LOCK;
        end
        R_SHDN:
        begin
          next_st.shdn = iam_merge(st.shdn, avs_writedata_in, avs_byteenable_in)
                         & SHDN_OK;
        end
        R_CFG:
        begin
          if (avs_byteenable_in[0])
          begin
            next_st.zp_open = avs_writedata_in[CFG_ZP_OPEN];
            next_st.pmode   = avs_writedata_in[CFG_PMODE];
          end
        end
        R_CTRL:
        begin
          if (avs_byteenable_in[0] && avs_writedata_in[CTRL_CLR])
          begin
            next_st.cnt  = '0;
            next_st.pend = pnd;
          end
        end
        R_RSEL:
        begin
          if (avs_byteenable_in[0])
          begin
            next_st.sel = avs_writedata_in[4:0];
          end
        end
        R_CYC:    next_st.cyc = iam_merge(st.cyc, avs_writedata_in,
                                          avs_byteenable_in);
        R_CYCPT:  next_st.cyc_pt = iam_merge(st.cyc_pt, avs_writedata_in,
                                             avs_byteenable_in);
        R_DBAND:  next_st.dband = 16'(iam_merge({16'h0, st.dband}, avs_writedata_in,
                                               avs_byteenable_in));
        R_ALLOW:
        begin
          next_st.allow = 16'(iam_merge({16'h0, st.allow}, avs_writedata_in,
                                        avs_byteenable_in));
        end
        R_TIME:
        begin
          next_st.tm       = iam_merge(st.tm, avs_writedata_in, avs_byteenable_in);
          next_st.time_apx = 1'b0;
        end
        default:
        begin
          next_st.rdata = st.rdata;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State register; restart restores defaults and drops latches
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      st <= IAM_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !st.ack;
  assign avs_readdata_out    = st.rdata;
  assign hart_resp_valid_out = st.hresp;
  assign hart_resp_ok_out    = st.hok;
  assign hart_status_out     = st.hstat;
  assign hart_cat_out        = st.hcat;
  assign alerts_out          = st.prev;
  assign rec_full_out        = st.cnt == REC_FULL;
  assign rec_not_empty_out   = st.cnt != 5'h00;
  assign autocal_busy_out    = st.acal_b;
  assign cal_busy_out        = st.cal_b;
  assign diag_busy_out       = st.diag_b;
  assign control_hold_out    = st.offl;

endmodule : iam_monitor

// [iam_monitor_sva.sv]
`timescale 1ns/1ns
module iam_monitor_sva
  import iam_pkg::*;
#(
  parameter logic [31:0] DRV_HOLD = DRV_HOLD_CYC
)
(
  // Clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             arst_n_in,
  // Bus and command port
  input  wire logic             avs_read_in,
  input  wire logic             avs_write_in,
  input  wire logic             avs_waitrequest_out,
  input  wire logic             hart_cmd_valid_in,
  input  wire logic [7:0]       hart_cmd_in,
  input  wire logic             hart_resp_valid_out,
  input  wire logic             hart_resp_ok_out,
  input  wire logic [31:0]      hart_status_out,
  // Measurements and status
  input  wire logic [15:0]      drive_in,
  input  wire logic             autocal_run_in,
  input  wire logic             cal_run_in,
  input  wire logic             diag_run_in,
  input  wire logic [31:0]      alerts_out,
  input  wire logic             rec_full_out,
  input  wire logic             rec_not_empty_out,
  input  wire logic             autocal_busy_out,
  input  wire logic             cal_busy_out,
  input  wire logic             diag_busy_out,
  input  wire logic             control_hold_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  // ---------------------------------------------------------------
  // Sequences
  // ---------------------------------------------------------------
  sequence s_bus_wait;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence s_cmd_taken;
    hart_cmd_valid_in;
  endsequence
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  a_bus_one_wait: assert property (s_bus_wait |=> !avs_waitrequest_out)
    else $error("bus answer late");
  a_resp_pulse: assert property (s_cmd_taken |=> hart_resp_valid_out)
    else $error("command not answered");
  a_resp_ok: assert property (hart_resp_valid_out |->
    hart_resp_ok_out == ($past(hart_cmd_in) == HART_CMD_STATUS)) else $error("ok flag wrong");
  a_refused_empty: assert property (hart_resp_valid_out && !hart_resp_ok_out |->
    hart_status_out == '0) else $error("refused command gave status");
  a_spare_zero: assert property (alerts_out[31:19] == '0 && hart_status_out[31:19] == '0)
    else $error("unused alert bit set");
  a_full_has_entries: assert property (rec_full_out |-> rec_not_empty_out)
    else $error("full without entries");
  a_busy_copy: assert property ({autocal_busy_out, cal_busy_out, diag_busy_out} ==
    {$past(autocal_run_in), $past(cal_run_in), $past(diag_run_in)})
    else $error("busy flag wrong");
  a_offline_stays: assert property (control_hold_out |=> control_hold_out)
    else $error("offline dropped");
  a_flash_latched: assert property (alerts_out[A_FLASH] |=> alerts_out[A_FLASH])
    else $error("flash alert dropped");
  a_drive_held: assert property ($rose(alerts_out[A_DRVSIG]) |->
    $past(drive_in, 8) < DRV_LO || $past(drive_in, 8) > DRV_HI)
    else $error("drive alert too soon");
endmodule : iam_monitor_sva

bind iam_monitor iam_monitor_sva #(.DRV_HOLD(DRV_HOLD)) i_iam_monitor_sva (.*);

// [iam_persist.sv]
`timescale 1ns/1ns
module iam_persist
  import iam_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        arst_n_in,
  // Condition and limit
  input  wire logic        cond_in,
  input  wire logic [31:0] limit_in,
  // Result
  output logic             held_out
);

  iam_tmr_t st;
  iam_tmr_t next_st;

  // ---------------------------------------------------------------
  // Count while the condition holds, restart on any break
  // ---------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    if (!cond_in)
    begin
      next_st.cnt  = '0;
      next_st.held = 1'b0;
    end
    else if (st.cnt != limit_in)
    begin
      next_st.cnt = st.cnt + 32'h00000001;
    end
    else
    begin
      // Saturate so a long hold never wraps back to zero
      next_st.held = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign held_out = st.held;

endmodule : iam_persist

// [iam_pkg.sv]
package iam_pkg;

  // ---------------------------------------------------------------
  // Alert numbering
  // ---------------------------------------------------------------
  localparam int N_AL      = 19;
  localparam int A_FLASH   = 0;
  localparam int A_REF     = 1;
  localparam int A_DRVCUR  = 2;
  localparam int A_CRITMEM = 3;
  localparam int A_SENSOR  = 4;
  localparam int A_LOOP    = 5;
  localparam int A_RNE     = 6;
  localparam int A_RFULL   = 7;
  localparam int A_CAL     = 8;
  localparam int A_AUTOCAL = 9;
  localparam int A_DIAG    = 10;
  localparam int A_CYC     = 11;
  localparam int A_TIME    = 12;
  localparam int A_DDATA   = 13;
  localparam int A_EPP     = 14;
  localparam int A_INTHI   = 15;
  localparam int A_INTLO   = 16;
  localparam int A_DRVSIG  = 17;
  localparam int A_OFFL    = 18;

  typedef enum logic [2:0] {
    CAT_NONE, CAT_FAIL, CAT_MAINT, CAT_FCHK, CAT_OOS
  } iam_cat_t;

  localparam int N_CAT = 5;
  localparam iam_cat_t IAM_CAT [N_AL] = '{
    CAT_FAIL, CAT_FAIL, CAT_FAIL, CAT_FAIL, CAT_FAIL, CAT_FAIL,
    CAT_MAINT, CAT_MAINT, CAT_FCHK, CAT_FCHK, CAT_FCHK, CAT_MAINT,
    CAT_NONE, CAT_NONE, CAT_OOS, CAT_OOS, CAT_OOS, CAT_OOS, CAT_FAIL
  };

  // ---------------------------------------------------------------
  // Defaults and locks
  // ---------------------------------------------------------------
  localparam logic [31:0] EN_RST  = 32'h0006403f;
  localparam logic [31:0] EN_LOCK = 32'h0000001f;
  localparam logic [31:0] SHDN_OK = 32'h00000020;

  // ---------------------------------------------------------------
  // Record and thresholds (travel, drive in 0.01 %, loop in 0.01 mA)
  // ---------------------------------------------------------------
  localparam int          REC_DEPTH = 20;
  localparam logic [4:0]  REC_FULL  = 5'h14;
  localparam logic [15:0] DRV_LO    = 16'h03e8;
  localparam logic [15:0] DRV_HI    = 16'h2328;
  localparam logic [15:0] TRV_LO    = 16'h012c;
  localparam logic [15:0] TRV_HI    = 16'h25e4;
  localparam logic [11:0] LOOP_MIN  = 12'h190;
  localparam logic [11:0] LOOP_MAX  = 12'h7d0;
  localparam logic [11:0] GROSS_LO  = 12'h12c;
  localparam logic [11:0] GROSS_HI  = 12'h960;
  localparam logic [7:0]  HART_CMD_STATUS = 8'h30;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam longint CLK_HZ     = 125_000_000;
  localparam longint DRV_HOLD_S = 20;
  localparam logic [31:0] DRV_HOLD_CYC = 32'(DRV_HOLD_S * CLK_HZ);

  // ---------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ---------------------------------------------------------------
  localparam logic [5:0] R_STATUS = 6'h00;
  localparam logic [5:0] R_EN     = 6'h04;
  localparam logic [5:0] R_SHDN   = 6'h08;
  localparam logic [5:0] R_CFG    = 6'h0c;
  localparam logic [5:0] R_CTRL   = 6'h10;
  localparam logic [5:0] R_RINFO  = 6'h14;
  localparam logic [5:0] R_RSEL   = 6'h18;
  localparam logic [5:0] R_RDATA  = 6'h1c;
  localparam logic [5:0] R_CYC    = 6'h20;
  localparam logic [5:0] R_CYCPT  = 6'h24;
  localparam logic [5:0] R_DBAND  = 6'h28;
  localparam logic [5:0] R_ALLOW  = 6'h2c;
  localparam logic [5:0] R_TIME   = 6'h30;
  localparam logic [5:0] R_CATS   = 6'h34;
  localparam int CFG_ZP_OPEN = 0;
  localparam int CFG_PMODE   = 1;
  localparam int CTRL_CLR    = 0;
  localparam int INFO_FULL   = 8;
  localparam int INFO_NE     = 9;

  // ---------------------------------------------------------------
  // State records
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0] cnt;
    logic        held;
  } iam_tmr_t;

  typedef struct packed {
    logic [31:0]                en;
    logic [31:0]                shdn;
    logic                       zp_open;
    logic                       pmode;
    logic [REC_DEPTH-1:0][4:0]  rec;
    logic [4:0]                 cnt;
    logic [4:0]                 sel;
    logic [31:0]                pend;
    logic [31:0]                prev;
    logic [31:0]                cyc;
    logic [31:0]                cyc_pt;
    logic [15:0]                dband;
    logic [15:0]                ref_pt;
    logic [15:0]                allow;
    logic                       dir_up;
    logic [31:0]                tm;
    logic                       flash_l;
    logic                       crit_l;
    logic                       loop_l;
    logic                       loop_chk;
    logic                       time_apx;
    logic                       offl;
    logic                       ack;
    logic [31:0]                rdata;
    logic                       cal_b;
    logic                       acal_b;
    logic                       diag_b;
    logic                       hresp;
    logic                       hok;
    logic [31:0]                hstat;
    logic [N_CAT-1:0]           hcat;
  } iam_state_t;

  localparam iam_state_t IAM_RST = '{en: EN_RST, time_apx: 1'b1, dir_up: 1'b1,
                                     default: '0};

endpackage : iam_pkg

// [test_instrument_alert_monitor.sv]
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module test_instrument_alert_monitor
  import iam_pkg::*;
;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, hv, wreq, hrv, hok, full, ne, hold;
  logic [5:0] adr = '0;
  logic [31:0] wd = '0, rdat, hst, alerts;
  logic [4:0] fl = '0, hcat;
  logic [3:0] run = '0;
  logic [2:0] bsy;
  logic [7:0] hc;
  logic [15:0] trv = '0, drv = 16'h1388, prs = '0;
  logic [11:0] lma = 12'h3e8;
  logic ihi = 1'b0, ilo = 1'b0;
  int n_fail = 0, checked = 0;
  logic [31:0] q;
  always #4 clk = ~clk;
  // Short hold count keeps the drive alert test brief
  iam_monitor #(.DRV_HOLD(32'h10)) i_iam_monitor (.core_clk_in(clk), .arst_n_in(rst_n),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
    .avs_byteenable_in(4'hf), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
    .flash_fail_in(fl[0]), .ref_fail_in(fl[1]), .drive_cur_fail_in(fl[2]),
    .crit_mem_fail_in(fl[3]), .sensor_fail_in(fl[4]), .autocal_run_in(run[0]),
    .cal_run_in(run[1]), .diag_run_in(run[2]), .diag_data_in(run[3]), .travel_in(trv),
    .drive_in(drv), .press_in(prs), .press_sp_in(16'h0000), .loop_ma_in(lma),
    .integ_hi_in(ihi), .integ_lo_in(ilo), .hart_cmd_valid_in(hv), .hart_cmd_in(hc),
    .hart_resp_valid_out(hrv), .hart_resp_ok_out(hok), .hart_status_out(hst),
    .hart_cat_out(hcat), .alerts_out(alerts), .rec_full_out(full),
    .rec_not_empty_out(ne), .autocal_busy_out(bsy[2]), .cal_busy_out(bsy[1]),
    .diag_busy_out(bsy[0]), .control_hold_out(hold));
  iam_hart_master i_iam_hart_master (.core_clk_in(clk), .cmd_valid_out(hv), .cmd_out(hc),
    .resp_valid_in(hrv), .resp_ok_in(hok), .status_in(hst), .cat_in(hcat));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    begin
      @(posedge clk);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      do @(posedge clk);
      while (wreq !== 1'b0);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
    end
  endtask : bus
  task automatic chkr(input logic [5:0] a, input logic [31:0] e);
    repeat (4) @(posedge clk);
    bus(1'b0, a, '0);
    `CHK(q, e)
  endtask : chkr
  task automatic hart(input logic [7:0] c, input logic eok, input logic [31:0] est,
                      input logic [4:0] ect);
    logic ok;
    logic [31:0] st;
    logic [4:0] ct;
    i_iam_hart_master.send(c, ok, st, ct);
    `CHK(ok, eok)
    `CHK(st, est)
    if (eok) `CHK(ct, ect)
  endtask : hart
  task automatic restart(input logic [11:0] l);
    @(posedge clk);
    rst_n <= 1'b0;
    lma <= l;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
  endtask : restart
  task automatic finish_test();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    finish_test();
  end
  initial
  begin
    static logic [31:0] tb [4] = '{32'h1, 32'h0, 32'h0, 32'h1};
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    chkr(R_EN, 32'h0006403f);
    bus(1'b1, R_EN, '0);
    chkr(R_EN, 32'h0000001f);
    bus(1'b1, R_SHDN, '1);
    chkr(R_SHDN, 32'h00000020);
    bus(1'b1, R_SHDN, '0);
    chkr(6'h3c, '0);
    chkr(R_STATUS, '0);
    hart(HART_CMD_STATUS, 1'b1, '0, '0);
    hart(8'h00, 1'b0, '0, '0);
    bus(1'b1, R_EN, 32'h0007c73f);
    run[2:0] <= 3'h7;
    ihi <= 1'b1;
    ilo <= 1'b1;
    chkr(R_STATUS, 32'h00018700);
    `CHK(bsy, 3'h7)
    hart(HART_CMD_STATUS, 1'b1, 32'h00018700, 5'h18);
    repeat (18)
    begin
      ihi <= 1'b0;
      repeat (2) @(posedge clk);
      ihi <= 1'b1;
      repeat (2) @(posedge clk);
    end
    chkr(R_RINFO, 32'h00000314);
    `CHK({full, ne}, 2'h3)
    bus(1'b1, R_RSEL, 32'h1);
    chkr(R_RDATA, 32'h8);
    bus(1'b1, R_RSEL, 32'h13);
    chkr(R_RDATA, 32'hf);
    run <= '0;
    ihi <= 1'b0;
    ilo <= 1'b0;
    `CHK(bsy, 3'h7)
    bus(1'b1, R_CTRL, 32'h1);
    chkr(R_RINFO, '0);
    `CHK({full, ne}, 2'h0)
    `CHK(bsy, 3'h0)
    bus(1'b1, R_DBAND, 32'h64);
    trv <= 16'h1388;
    bus(1'b1, R_CYC, '0);
    trv <= 16'h07d0;
    repeat (4) @(posedge clk);
    trv <= 16'h1388;
    chkr(R_CYC, 32'h2);
    bus(1'b1, R_CYCPT, 32'h5);
    bus(1'b1, R_EN, 32'h0006783f);
    chkr(R_STATUS, 32'h00001000);
    bus(1'b1, R_TIME, 32'h5);
    chkr(R_STATUS, '0);
    bus(1'b1, R_CYC, 32'ha);
    chkr(R_STATUS, 32'h00000800);
    bus(1'b1, R_CYC, 32'h4);
    chkr(R_STATUS, '0);
    run[3] <= 1'b1;
    chkr(R_STATUS, 32'h00002000);
    run[3] <= 1'b0;
    prs <= 16'h07d0;
    bus(1'b1, R_ALLOW, 32'h64);
    chkr(R_STATUS, '0);
    bus(1'b1, R_CFG, 32'h2);
    chkr(R_STATUS, 32'h00004000);
    prs <= '0;
    bus(1'b1, R_EN, 32'h0006403f);
    // Zero power mode, drive, travel; even rows closed
    for (int i = 0; i < 4; i++)
    begin
      drv <= 16'h1388;
      bus(1'b1, R_CFG, i[0]);
      drv <= i[1] ? 16'h251c : 16'h01f4;
      trv <= (i == 0 || i == 3) ? 16'h1388 : 16'h2648;
      chkr(R_STATUS, '0);
      repeat (20) @(posedge clk);
      chkr(R_STATUS, tb[i][0] ? 32'h00020000 : '0);
    end
    drv <= 16'h1388;
    fl[0] <= 1'b1;
    @(posedge clk);
    fl[0] <= 1'b0;
    bus(1'b1, R_CTRL, 32'h1);
    bus(1'b1, R_EN, '0);
    chkr(R_STATUS, 32'h1);
    `CHK(alerts, 32'h1)
    restart(12'h064);
    chkr(R_STATUS, 32'h00000020);
    `CHK(hold, 1'b0)
    bus(1'b1, R_SHDN, 32'h20);
    chkr(R_STATUS, 32'h00040020);
    `CHK(hold, 1'b1)
    restart(12'h3e8);
    chkr(R_STATUS, '0);
    finish_test();
  end
endmodule : test_instrument_alert_monitor
